//--- rtl/ftpo_top.sv
// flow totalizers with flow-proportional relay pulse output
// assumes flow samples come from logic on hclk, the button from a pin
//
// Local design decisions: the AHB-Lite register port and the register offsets.
`timescale 1ns/100ps
module ftpo_top #(
  parameter int unsigned SEC_CYCLES = ftpo_pkg::SEC_CYCLES,
  parameter int unsigned MS_CYCLES = ftpo_pkg::MS_CYCLES
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // flow measurement and field button
  input wire ftpo_pkg::ftpo_flow_s flow,
  input wire logic maint_btn,
  // nonvolatile store
  input wire ftpo_pkg::ftpo_nvm_s nvm_restore,
  output ftpo_pkg::ftpo_nvm_s nvm_save,
  // outputs
  output logic [1:0] tot_event,
  output logic relay_output
);
  import ftpo_pkg::*;

  // configuration state
  logic [7:0] ctrl;
  logic [9:0] cfg_start [2];
  logic [31:0] cfg_act [2];
  logic [11:0] cfg_pon [2];
  logic [11:0] cfg_ard [2];
  logic [2:0] cfg_dp [2];
  logic [9:0] cfg_pstart;
  logic [31:0] cfg_punit;
  logic [15:0] cfg_pon_ms;
  logic [15:0] cfg_sdt;

  // bus pipeline
  logic wr_pend;
  logic [7:0] wr_addr;
  wire addr_ph = hsel & hready & htrans[1];
  wire word_sz = hsize == 3'h2;
  wire [7:0] ra = haddr[7:0];
  logic [31:0] rd_data;

  // block state seen by reads
  logic [31:0] tot [2];
  logic [31:0] reading [2];
  logic [11:0] ard_cnt [2];
  logic [1:0] ard_busy;
  logic loaded;
  logic [7:0] queue;
  ftpo_pstate_e pstate;

  // slave always ready and always okay; no wait states are ever needed
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // address phase captured, write data lands one cycle later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pend <= addr_ph & hwrite & word_sz;
      wr_addr <= ra;
      hrdata <= (addr_ph & !hwrite) ? rd_data : 32'h0000_0000;
    end
  end

  // write field clamps keep stored settings inside their legal ranges
  function automatic logic [11:0] clamp_dly(input logic [31:0] v);
    clamp_dly = (v > 32'(DELAY_MAX_S)) ? DELAY_MAX_S : v[11:0];
  endfunction

  function automatic logic [9:0] clamp_thr(input logic [31:0] v);
    clamp_thr = (v > 32'(THR_STEPS)) ? THR_STEPS : v[9:0];
  endfunction

  function automatic logic [2:0] clamp_dp(input logic [3:0] v);
    clamp_dp = (v > {1'b0, DP_MAX}) ? DP_MAX : v[2:0];
  endfunction

  function automatic logic [31:0] pow10(input logic [2:0] d);
    case (d)
      3'h0: pow10 = 32'h0000_0001;
      3'h1: pow10 = 32'h0000_000A;
      3'h2: pow10 = 32'h0000_0064;
      3'h3: pow10 = 32'h0000_03E8;
      3'h4: pow10 = 32'h0000_2710;
      default: pow10 = 32'h0001_86A0;
    endcase
  endfunction

  wire [15:0] on_in = hwdata[15:0];
  wire [15:0] on_lo = (on_in < PULSE_ON_MIN_MS) ? PULSE_ON_MIN_MS : on_in;
  wire [15:0] on_clamped = (on_lo > PULSE_ON_MAX_MS) ? PULSE_ON_MAX_MS : on_lo; // [RULE17]

  // configuration writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= CTRL_RST; // [RULE4] [RULE9] [RULE12]
      cfg_start[0] <= 10'h000;
      cfg_start[1] <= 10'h000;
      cfg_act[0] <= ACT_RST; // [RULE7]
      cfg_act[1] <= ACT_RST;
      cfg_pon[0] <= DLY_RST;
      cfg_pon[1] <= DLY_RST;
      cfg_ard[0] <= DLY_RST;
      cfg_ard[1] <= DLY_RST;
      cfg_dp[0] <= 3'h0;
      cfg_dp[1] <= 3'h0;
      cfg_pstart <= 10'h000;
      cfg_punit <= PUNIT_RST;
      cfg_pon_ms <= PULSE_ON_MIN_MS;
      cfg_sdt <= SDT_RST;
    end else if (wr_pend) begin
      case (wr_addr)
        OFF_CTRL: ctrl <= hwdata[7:0];
        OFF_START0: cfg_start[0] <= clamp_thr(hwdata);
        OFF_START1: cfg_start[1] <= clamp_thr(hwdata);
        OFF_ACT0: cfg_act[0] <= hwdata;
        OFF_ACT1: cfg_act[1] <= hwdata;
        OFF_PON0: cfg_pon[0] <= clamp_dly(hwdata); // [RULE8]
        OFF_PON1: cfg_pon[1] <= clamp_dly(hwdata);
        OFF_ARD0: cfg_ard[0] <= clamp_dly(hwdata); // [RULE10]
        OFF_ARD1: cfg_ard[1] <= clamp_dly(hwdata);
        OFF_DPREC: begin
          cfg_dp[0] <= clamp_dp(hwdata[3:0]); // [RULE13]
          cfg_dp[1] <= clamp_dp(hwdata[DP1_POS +: 4]);
        end
        OFF_PSTART: cfg_pstart <= clamp_thr(hwdata); // [RULE15]
        OFF_PUNIT: cfg_punit <= hwdata; // [RULE16]
        OFF_PONTIME: cfg_pon_ms <= on_clamped;
        OFF_SDT: cfg_sdt <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  // control fields
  wire [1:0] tot_en = ctrl[CTRL_TEN +: 2];
  wire [1:0] ar_en = ctrl[CTRL_AR +: 2];
  wire lock = ctrl[CTRL_LOCK];
  wire pls_en = ctrl[CTRL_PEN];
  wire [1:0] relay_func = ctrl[CTRL_RF +: 2];

  // read selection; unmapped offsets read zero
  assign rd_data =
    (ra == OFF_CTRL) ? {24'h0, ctrl} :
    (ra == OFF_START0) ? {22'h0, cfg_start[0]} :
    (ra == OFF_START1) ? {22'h0, cfg_start[1]} :
    (ra == OFF_ACT0) ? cfg_act[0] :
    (ra == OFF_ACT1) ? cfg_act[1] :
    (ra == OFF_PON0) ? {20'h0, cfg_pon[0]} :
    (ra == OFF_PON1) ? {20'h0, cfg_pon[1]} :
    (ra == OFF_ARD0) ? {20'h0, cfg_ard[0]} :
    (ra == OFF_ARD1) ? {20'h0, cfg_ard[1]} :
    (ra == OFF_DPREC) ? {25'h0, cfg_dp[1], 1'b0, cfg_dp[0]} :
    (ra == OFF_PSTART) ? {22'h0, cfg_pstart} :
    (ra == OFF_PUNIT) ? cfg_punit :
    (ra == OFF_PONTIME) ? {16'h0, cfg_pon_ms} :
    (ra == OFF_SDT) ? {16'h0, cfg_sdt} :
    (ra == OFF_READ0) ? reading[0] :
    (ra == OFF_READ1) ? reading[1] :
    (ra == OFF_STATUS) ? {16'h0, queue, 2'h0, ard_busy, loaded, relay_output, tot_event} :
    32'h0000_0000;

  // confirmed software reset: key in the upper half, target bits below
  wire key_ok = hwdata[31:16] == RST_KEY;
  wire rst_cmd = wr_pend & (wr_addr == OFF_RESET) & key_ok;
  wire [1:0] sw_rst = rst_cmd ? hwdata[1:0] : 2'b00;

  // button synchroniser, edge detect taken from the second stage only
  logic btn_m;
  logic btn_s;
  logic btn_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      btn_m <= 1'b0;
      btn_s <= 1'b0;
      btn_q <= 1'b0;
    end else begin
      btn_m <= maint_btn;
      btn_s <= btn_m;
      btn_q <= btn_s;
    end
  end
  wire btn_press = btn_s & !btn_q;
  // a held lock swallows both request sources
  wire [1:0] man_clr = (sw_rst | {2{btn_press}}) & {2{!lock}}; // [RULE11] [RULE12]

  // one-second time base and uptime since reset
  logic [31:0] sec_cnt;
  logic [11:0] uptime;
  wire sec_tick = sec_cnt == (SEC_CYCLES - 32'd1);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sec_cnt <= 32'h0000_0000;
      uptime <= 12'h000;
    end else begin
      sec_cnt <= sec_tick ? 32'h0000_0000 : sec_cnt + 32'd1;
      if (sec_tick && uptime != DELAY_MAX_S)
        uptime <= uptime + 12'd1;
    end
  end

  // flow increment shared by both totalizers and the pulse sum
  wire [31:0] inc = {16'h0, flow.rate} * {16'h0, cfg_sdt}; // [RULE21]
  wire [26:0] rate_x = 27'(flow.rate) * 27'(THR_STEPS);

  // restore is taken once, on the first valid word after reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      loaded <= 1'b0;
    else if (nvm_restore.valid)
      loaded <= 1'b1;
  end

  // two identical totalizers
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_tot
      wire [26:0] thr_x = 27'(cfg_start[gi]) * 27'(FLOW_FS);
      wire thr_ok = rate_x >= thr_x; // [RULE5]
      wire pon_ok = uptime >= cfg_pon[gi]; // [RULE8]
      wire [32:0] sum = {1'b0, tot[gi]} + {1'b0, inc};
      wire [31:0] sat = sum[32] ? 32'hFFFF_FFFF : sum[31:0];
      wire ev = (cfg_act[gi] != 32'h0) && (tot[gi] >= cfg_act[gi]); // [RULE6] [RULE7]
      wire auto_clr = ev & ar_en[gi]; // [RULE9]
      wire run = loaded & tot_en[gi] & pon_ok & !ard_busy[gi] & flow.valid & thr_ok; // [RULE4]
      wire [31:0] rest = (gi == 0) ? nvm_restore.tot0 : nvm_restore.tot1;
      assign ard_busy[gi] = ard_cnt[gi] != 12'h000;

      // clears win over restore and accumulation in the same cycle
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
          tot[gi] <= 32'h0000_0000;
        else if (man_clr[gi] || auto_clr)
          tot[gi] <= 32'h0000_0000; // [RULE11]
        else if (nvm_restore.valid && !loaded)
          tot[gi] <= rest; // [RULE3]
        else if (run)
          tot[gi] <= sat; // [RULE1] [RULE21]
      end

      // hold-off after an automatic batch reset, counted in seconds
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
          ard_cnt[gi] <= 12'h000;
        else if (auto_clr)
          ard_cnt[gi] <= cfg_ard[gi]; // [RULE10]
        else if (sec_tick && ard_busy[gi])
          ard_cnt[gi] <= ard_cnt[gi] - 12'd1;
      end

      // scaled reading; 32 bits never exceed ten decimal digits
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          reading[gi] <= 32'h0000_0000;
          tot_event[gi] <= 1'b0;
        end else begin
          reading[gi] <= tot[gi] / pow10(cfg_dp[gi]); // [RULE13]
          tot_event[gi] <= ev; // [RULE6]
        end
      end
    end
  endgenerate

  // periodic save of both totals after restore while either one is enabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nvm_save <= '0;
    end else begin
      nvm_save.valid <= sec_tick & loaded & (|tot_en); // [RULE2]
      nvm_save.tot0 <= tot[0];
      nvm_save.tot1 <= tot[1];
    end
  end

  // pulse sum: independent of the totalizers and their resets
  logic [31:0] pacc;
  wire [26:0] pthr_x = 27'(cfg_pstart) * 27'(FLOW_FS);
  wire padd = pls_en & flow.valid & (rate_x >= pthr_x); // [RULE14] [RULE15]
  wire earn = (cfg_punit != 32'h0) && (pacc >= cfg_punit); // [RULE16]
  wire [31:0] pless = earn ? pacc - cfg_punit : pacc;
  wire [32:0] psum = {1'b0, pless} + {1'b0, (padd ? inc : 32'h0)};
  wire [31:0] next_pacc = psum[32] ? 32'hFFFF_FFFF : psum[31:0];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      pacc <= 32'h0000_0000;
    else
      pacc <= next_pacc; // [RULE21]
  end

  // emitter timing in milliseconds; the ms divider restarts at each pulse
  logic [31:0] ms_cnt;
  logic [15:0] on_left;
  logic [15:0] per_left;
  wire emit = (pstate == PS_IDLE) && (queue != 8'h00) && pls_en;
  wire ms_tick = ms_cnt == (MS_CYCLES - 32'd1);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      ms_cnt <= 32'h0000_0000;
    else if (emit || ms_tick)
      ms_cnt <= 32'h0000_0000;
    else
      ms_cnt <= ms_cnt + 32'd1;
  end

  // backlog: earned pulses wait here, saturating rather than wrapping
  wire q_up = earn && (queue != QUEUE_MAX);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      queue <= 8'h00;
    else if (q_up && !emit)
      queue <= queue + 8'd1; // [RULE19] [RULE22]
    else if (emit && !q_up)
      queue <= queue - 8'd1; // [RULE22]
  end

  // pulse state: on for the on-time, then low until the period has run
  ftpo_pstate_e next_pstate;
  always_comb begin
    next_pstate = pstate;
    case (pstate)
      PS_IDLE: if (emit) next_pstate = PS_ON;
      PS_ON: if (ms_tick && on_left == 16'd1) next_pstate = PS_OFF; // [RULE17]
      PS_OFF: if (ms_tick && per_left <= 16'd1) next_pstate = PS_IDLE; // [RULE18]
      default: next_pstate = PS_IDLE;
    endcase
  end

  // the off state lasts at least one ms, so long on-times still show a gap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pstate <= PS_IDLE;
      on_left <= 16'h0000;
      per_left <= 16'h0000;
    end else begin
      pstate <= next_pstate;
      if (emit) begin
        on_left <= cfg_pon_ms;
        per_left <= PULSE_PERIOD_MS;
      end else if (ms_tick) begin
        if (on_left != 16'h0000)
          on_left <= on_left - 16'd1;
        if (per_left != 16'h0000)
          per_left <= per_left - 16'd1;
      end
    end
  end

  // relay function assignment selects the relay source
  wire pulse_on = pstate == PS_ON;
  wire next_relay = (relay_func == RF_PULSE) ? pulse_on : // [RULE20]
                    (relay_func == RF_EV0) ? tot_event[0] :
                    (relay_func == RF_EV1) ? tot_event[1] : 1'b0;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      relay_output <= 1'b0;
    else
      relay_output <= next_relay;
  end

endmodule

//--- common/ftpo_pkg.sv
// constants, register map and carrier types of the flow totalizer and pulse block
// assumes one 250 MHz clock and an AHB-Lite register port
// Contract
// RULE1: two independent totalizers integrate mass flow rate over time.
// RULE2: each totalizer value is saved to nonvolatile memory once per second; here only after restore and while either totalizer is enabled.
// RULE3: at power-up each totalizer reloads its last saved value.
// RULE4: per-totalizer enable, default off; no accumulation while off.
// RULE5: accumulate only while flow is at or above the start threshold.
// RULE6: action event while reading is at or above the action volume.
// RULE7: action volume zero disables the event; zero is the default.
// RULE8: no accumulation until the power-on delay, 0 to 3600 s, has passed.
// RULE9: auto reset, default off, clears the reading at the action volume.
// RULE10: after auto reset wait the auto reset delay before the next batch.
// RULE11: confirmed software reset or maintenance button clears the reading.
// RULE12: reset lock, default off, ignores every totalizer reset request; here the lock masks only the software and button resets, not the auto reset.
// RULE13: reading shown in ten digits, precision reduced by 0 to 5 digits.
// RULE14: pulse generator runs apart from totalizers, rate follows flow.
// RULE15: pulse enable; pulses only while flow is at or above its threshold.
// RULE16: one pulse per configured quantity of accumulated flow.
// RULE17: pulse on-time is configurable from 50 to 6553 ms.
// RULE18: pulses start no closer than 100 ms apart.
// RULE19: pulses earned too fast wait in a backlog queue.
// RULE20: pulses reach the relay only when relay function selects pulses.
// RULE21: each sample adds rate times sample interval to totals and pulse sum.
// RULE22: the queue counter saturates and drops by one per emitted pulse.
package ftpo_pkg;
  localparam int CLK_HZ = 250_000_000;
  localparam int SEC_S = 1;
  localparam int SEC_CYCLES = CLK_HZ * SEC_S;
  localparam int TICK_MS = 1;
  localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam logic [15:0] PULSE_ON_MIN_MS = 16'h0032;
  localparam logic [15:0] PULSE_ON_MAX_MS = 16'h1999;
  localparam logic [15:0] PULSE_PERIOD_MS = 16'h0064;
  localparam logic [11:0] DELAY_MAX_S = 12'hE10;
  localparam logic [9:0] THR_STEPS = 10'h3E8;
  localparam logic [15:0] FLOW_FS = 16'hFFFF;
  localparam logic [2:0] DP_MAX = 3'h5;
  localparam logic [15:0] RST_KEY = 16'hA5C3;
  localparam logic [7:0] QUEUE_MAX = 8'hFF;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_START0 = 8'h04;
  localparam logic [7:0] OFF_START1 = 8'h08;
  localparam logic [7:0] OFF_ACT0 = 8'h0C;
  localparam logic [7:0] OFF_ACT1 = 8'h10;
  localparam logic [7:0] OFF_PON0 = 8'h14;
  localparam logic [7:0] OFF_PON1 = 8'h18;
  localparam logic [7:0] OFF_ARD0 = 8'h1C;
  localparam logic [7:0] OFF_ARD1 = 8'h20;
  localparam logic [7:0] OFF_DPREC = 8'h24;
  localparam logic [7:0] OFF_PSTART = 8'h28;
  localparam logic [7:0] OFF_PUNIT = 8'h2C;
  localparam logic [7:0] OFF_PONTIME = 8'h30;
  localparam logic [7:0] OFF_SDT = 8'h34;
  localparam logic [7:0] OFF_RESET = 8'h38;
  localparam logic [7:0] OFF_READ0 = 8'h3C;
  localparam logic [7:0] OFF_READ1 = 8'h40;
  localparam logic [7:0] OFF_STATUS = 8'h44;
  // control field positions
  localparam int CTRL_TEN = 0;
  localparam int CTRL_AR = 2;
  localparam int CTRL_LOCK = 4;
  localparam int CTRL_PEN = 5;
  localparam int CTRL_RF = 6;
  localparam int DP1_POS = 4;
  // values after reset
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [31:0] ACT_RST = 32'h0000_0000;
  localparam logic [11:0] DLY_RST = 12'h000;
  localparam logic [15:0] SDT_RST = 16'h0001;
  localparam logic [31:0] PUNIT_RST = 32'h0000_0001;
  typedef struct packed {
    logic valid;
    logic [15:0] rate;
  } ftpo_flow_s;
  typedef struct packed {
    logic valid;
    logic [31:0] tot0;
    logic [31:0] tot1;
  } ftpo_nvm_s;
  typedef enum logic [2:0] {
    PS_IDLE = 3'b001,
    PS_ON = 3'b010,
    PS_OFF = 3'b100
  } ftpo_pstate_e;
  typedef enum logic [1:0] {
    RF_NONE = 2'h0,
    RF_PULSE = 2'h1,
    RF_EV0 = 2'h2,
    RF_EV1 = 2'h3
  } ftpo_relay_e;
endpackage

//--- test/ftpo_monitor.sv
// port-level checker for the flow totalizer and pulse block
// assumes it is bound onto ftpo_top and handed the same timing parameters
`timescale 1ns/100ps
module ftpo_monitor #(
  parameter int unsigned SEC_CYCLES = 100,
  parameter int unsigned MS_CYCLES = 10
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // outputs
  input wire ftpo_pkg::ftpo_nvm_s nvm_save,
  input wire logic [1:0] tot_event,
  input wire logic relay_output
);
  import ftpo_pkg::*;
  logic take;
  logic wr_ph;
  logic [7:0] wr_off;
  logic [7:0] ctrl_q;
  logic [31:0] act0_q;
  logic [31:0] act1_q;
  int unsigned on_cnt;
  int unsigned rise_gap;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  assign take = hsel && hready && htrans[1] && hwrite && hsize == 3'h2;
  // shadow words land on the same edge as the block's own write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph <= 1'b0;
      wr_off <= 8'h00;
      ctrl_q <= 8'h00;
      act0_q <= 32'h0;
      act1_q <= 32'h0;
    end else begin
      wr_ph <= take;
      wr_off <= haddr[7:0];
      if (wr_ph && wr_off == OFF_CTRL) ctrl_q <= hwdata[7:0];
      if (wr_ph && wr_off == OFF_ACT0) act0_q <= hwdata;
      if (wr_ph && wr_off == OFF_ACT1) act1_q <= hwdata;
    end
  end
  // relay high time and span between rises; span starts saturated
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      on_cnt <= 0;
      rise_gap <= 32'hFFFF_FFFF;
    end else begin
      on_cnt <= relay_output ? on_cnt + 1 : 0;
      rise_gap <= $rose(relay_output) ? 1 : (&rise_gap ? rise_gap : rise_gap + 1);
    end
  end
  relay_min_a: assert property (
    $fell(relay_output) |-> on_cnt >= 50 * MS_CYCLES) else $error("relay pulse too short");
  relay_max_a: assert property (
    relay_output |-> on_cnt < 6553 * MS_CYCLES) else $error("relay pulse too long");
  pulse_gap_a: assert property (
    $rose(relay_output) |-> rise_gap >= 100 * MS_CYCLES) else $error("pulses too close");
  rf_none_a: assert property (
    ctrl_q[7:6] == 2'h0 && $past(ctrl_q[7:6]) == 2'h0 |-> !relay_output)
    else $error("relay driven with no function");
  pulse_off_a: assert property (
    $rose(relay_output) && ctrl_q[7:6] == 2'h1 |-> $past(ctrl_q[5], 2))
    else $error("pulse started while disabled");
  act0_off_a: assert property (
    act0_q == 0 && $past(act0_q) == 0 && $past(act0_q, 2) == 0 |-> !tot_event[0])
    else $error("event with zero action volume");
  act1_off_a: assert property (
    act1_q == 0 && $past(act1_q) == 0 && $past(act1_q, 2) == 0 |-> !tot_event[1])
    else $error("event with zero action volume");
  save_space_a: assert property (
    nvm_save.valid |=> !nvm_save.valid [*8]) else $error("saves too close");
  save_idle_a: assert property (
    ctrl_q[1:0] == 2'h0 && $past(ctrl_q[1:0]) == 2'h0 |-> !nvm_save.valid)
    else $error("save while disabled");
  cover property ($rose(relay_output));
  cover property ($rose(tot_event[0]));
  cover property (nvm_save.valid);
endmodule
bind ftpo_top ftpo_monitor #(.SEC_CYCLES(SEC_CYCLES), .MS_CYCLES(MS_CYCLES)) u_mon (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .nvm_save(nvm_save), .tot_event(tot_event), .relay_output(relay_output));

//--- test/ftpo_field.sv
// flow source, field button, saved totals and relay load around the block
// assumes the bench calls its tasks; all strobes move just after hclk rises
`timescale 1ns/100ps
module ftpo_field (
  // clock
  input wire logic hclk,
  // towards the block
  output ftpo_pkg::ftpo_flow_s flow,
  output logic maint_btn,
  output ftpo_pkg::ftpo_nvm_s nvm_restore,
  // relay contact
  input wire logic relay_output
);
  import ftpo_pkg::*;
  int n_rise = 0;
  int last_on = 0;
  int last_gap = 0;
  int on_c = 0;
  int gap_c = 0;
  logic rly_q = 1'b0;
  initial begin
    flow = '0;
    maint_btn = 1'b0;
    nvm_restore = '0;
  end
  // one sample; the rate word is scrambled once the strobe drops
  task automatic sample(input logic [15:0] rate);
    @(posedge hclk);
    flow <= {1'b1, rate};
    @(posedge hclk);
    flow <= {1'b0, ~rate};
    repeat (4) @(posedge hclk);
  endtask
  // saved totals offered once, as the store would after power-up
  task automatic restore(input logic [31:0] t0, input logic [31:0] t1);
    @(posedge hclk);
    nvm_restore <= {1'b1, t0, t1};
    @(posedge hclk);
    nvm_restore <= {1'b0, ~t0, ~t1};
    repeat (4) @(posedge hclk);
  endtask
  // button held long enough to pass the two-stage synchroniser
  task automatic press();
    @(posedge hclk);
    maint_btn <= 1'b1;
    repeat (6) @(posedge hclk);
    maint_btn <= 1'b0;
    repeat (6) @(posedge hclk);
  endtask
  // closure timing as the load sees it
  always @(posedge hclk) begin
    gap_c <= gap_c + 1;
    if (relay_output) on_c <= on_c + 1;
    if (relay_output && !rly_q) begin
      n_rise <= n_rise + 1;
      last_gap <= gap_c;
      gap_c <= 1;
      on_c <= 1;
    end
    if (!relay_output && rly_q) last_on <= on_c;
    rly_q <= relay_output;
  end
endmodule

//--- test/tb.sv
// self-checking bench for the flow totalizer and pulse block
// assumes short second and millisecond counts so the run stays brief
`timescale 1ns/100ps
module tb;
  import ftpo_pkg::*;
  localparam int unsigned SEC_C = 100;
  localparam int unsigned MS_C = 10;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, maint_btn, relay_output;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0] htrans, tot_event;
  logic [2:0] hsize;
  ftpo_flow_s flow;
  ftpo_nvm_s nvm_restore, nvm_save;
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int i;
  ftpo_top #(.SEC_CYCLES(SEC_C), .MS_CYCLES(MS_C)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .flow(flow),
    .maint_btn(maint_btn), .nvm_restore(nvm_restore), .nvm_save(nvm_save),
    .tot_event(tot_event), .relay_output(relay_output));
  ftpo_field u_fld (.hclk(hclk), .flow(flow), .maint_btn(maint_btn),
    .nvm_restore(nvm_restore), .relay_output(relay_output));
  task automatic print_verdict();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one single word transfer; waits on hready in both phases
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {~a, 16'h0000, a}; // upper address bits are not decoded
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rv, exp);
  endtask
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // hang guard
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      print_verdict();
    end
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rc(OFF_CTRL, 32'h0);
    rc(OFF_ACT0, 32'h0);
    rc(OFF_PON0, 32'h0);
    rc(OFF_ARD1, 32'h0);
    rc(OFF_PONTIME, 32'h32);
    rc(8'h48, 32'h0);
    u_fld.restore(32'h5, 32'h7);
    rc(OFF_READ0, 32'h5);
    rc(OFF_READ1, 32'h7);
    u_fld.sample(16'h0064);
    rc(OFF_READ0, 32'h5);
    wr(OFF_CTRL, 32'h1);
    wr(OFF_PON0, 32'hE10);
    u_fld.sample(16'h0064);
    rc(OFF_READ0, 32'h5);
    wr(OFF_PON0, 32'h0);
    u_fld.sample(16'h0064);
    rc(OFF_READ0, 32'h69);
    rc(OFF_READ1, 32'h7);
    for (i = 0; i < 300 && nvm_save.valid !== 1'b1; i++) @(posedge hclk);
    chk({31'h0, nvm_save.valid}, 32'h1);
    chk(nvm_save.tot0, 32'h69);
    chk(nvm_save.tot1, 32'h7);
    // threshold 50.0 percent: one step below full half scale is refused
    wr(OFF_START0, 32'h1F4);
    u_fld.sample(16'h7FFF);
    rc(OFF_READ0, 32'h69);
    u_fld.sample(16'h8000);
    rc(OFF_READ0, 32'h8069);
    wr(OFF_START0, 32'h0);
    wr(OFF_ACT0, 32'h806A);
    chk({30'h0, tot_event}, 32'h0);
    u_fld.sample(16'h0001);
    chk({30'h0, tot_event}, 32'h1);
    wr(OFF_DPREC, 32'h2);
    rc(OFF_READ0, 32'h148);
    wr(OFF_DPREC, 32'h0);
    // a halfword write must not land
    hsize <= 3'h1;
    wr(OFF_ACT1, 32'h55);
    hsize <= 3'h2;
    rc(OFF_ACT1, 32'h0);
    wr(OFF_CTRL, 32'h11);
    wr(OFF_RESET, 32'hA5C3_0001);
    u_fld.press();
    rc(OFF_READ0, 32'h806A);
    wr(OFF_CTRL, 32'h1);
    wr(OFF_RESET, 32'h1234_0001);
    rc(OFF_READ0, 32'h806A);
    wr(OFF_RESET, 32'hA5C3_0001);
    rc(OFF_READ0, 32'h0);
    chk({30'h0, tot_event}, 32'h0);
    u_fld.press();
    rc(OFF_READ1, 32'h0);
    wr(OFF_ACT0, 32'hA);
    wr(OFF_CTRL, 32'h5);
    u_fld.sample(16'h000A);
    rc(OFF_READ0, 32'h0);
    wr(OFF_ARD0, 32'h2);
    u_fld.sample(16'h000A);
    u_fld.sample(16'h0003);
    rc(OFF_READ0, 32'h0);
    repeat (250) @(posedge hclk);
    u_fld.sample(16'h0003);
    rc(OFF_READ0, 32'h3);
    // two pulses earned at once leave through the backlog
    wr(OFF_CTRL, 32'h60);
    wr(OFF_PUNIT, 32'h64);
    u_fld.sample(16'h00FA);
    for (i = 0; i < 3000 && u_fld.n_rise < 2; i++) @(posedge hclk);
    repeat (600) @(posedge hclk);
    chk(u_fld.n_rise, 2);
    chk(u_fld.last_on, 50 * MS_C);
    // one idle cycle sits between the end of a period and the next start
    chk(u_fld.last_gap, 100 * MS_C + 1);
    rc(OFF_READ0, 32'h3);
    wr(OFF_CTRL, 32'h20);
    u_fld.sample(16'h0064);
    repeat (1500) @(posedge hclk);
    chk(u_fld.n_rise, 2);
    wr(OFF_CTRL, 32'h60);
    wr(OFF_PSTART, 32'h3E8);
    u_fld.sample(16'hFFFE);
    repeat (1500) @(posedge hclk);
    chk(u_fld.n_rise, 2);
    // relay follows the first totalizer's event when so assigned
    wr(OFF_CTRL, 32'h80);
    wr(OFF_ACT0, 32'h3);
    repeat (3) @(posedge hclk);
    chk({31'h0, relay_output}, 32'h1);
    print_verdict();
  end
endmodule
